// ==== ddr3_pin_defines.svh ====
// Functional notes
// - Address and control pins are captured on each rising link clock edge.
// - Clock gate high runs the device; low enters power-down or self refresh.
// - Clock gate wakes the device from self refresh without a clock edge.
// - Power-down keeps clock, termination, gate buffers; self refresh only gate.
// - A cycle with chip select high carries no command.
// - Command decoded from chip select and three strobes on one edge.
// - Termination control terminates data pins, plus the termination strobe in its mode, when enabled in mode one.
// - Mode one bit eleven picks termination strobe or write mask.
// - Write beats with the mask high are discarded.
// - Bank lines pick the bank, or the mode register on a load.
// - Address lines give row, column or mode register opcode.
// - Auto-close flag on access closes the bank after the burst.
// - Auto-close flag on precharge closes all banks, else one.
// - Burst cut flag low chops to four when on-the-fly is set.
// - Active-low reset pin resets the device asynchronously.
// - Device drives strobe with read data; controller drives it on writes.
// - Strobe is only used as a differential pair.
// - Accesses run four or eight beats from the start column.
// - Access address gives column, auto-close and burst length choice.
// - Mode register load is all four command lines low.
// - Burst setting offers fixed four, fixed eight, or per-command choice.
// - Termination stays off in reset and until clock gate registers high.
`ifndef DDR3_PIN_DEFINES_SVH
`define DDR3_PIN_DEFINES_SVH
// Command codes as {chip select, row, column, write strobe}
`define CMD_MODE_LOAD 4'h0
`define CMD_REF 4'h1
`define CMD_PRE 4'h2
`define CMD_ACT 4'h3
`define CMD_WR 4'h4
`define CMD_RD 4'h5
// Address bit roles
`define AP_BIT 10
`define BC_BIT 12
`define TSTROBE_BIT 11
// Mode register indexes and fields
`define MR0_IDX 2'h0
`define MODE_ONE_IDX 2'h1
`define BL_MSB 1
`define BL_LSB 0
`define BL_FIX8 2'h0
`define BL_OTF 2'h1
`define BL_FIX4 2'h2
`define RTT_MASK 16'h0244
// Beat pairs per burst, one pair per link clock
`define PAIRS_FULL 3'h4
`define PAIRS_CHOP 3'h2
// Reset values
`define MR_RST 16'h0000
`define ROW_RST 16'h0000
`define BANK_NONE 8'h00
`endif

// ==== ddr3_pin_pkg.sv ====
package ddr3_pin_pkg;
  typedef enum logic [1:0] {
    PW_RUN = 2'h0,
    PW_PDN = 2'h1,
    PW_SREF = 2'h2
  } power_e;
  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [2:0] bank_pick;
    logic [15:0] addr;
  } cmd_s;
  typedef struct packed {
    logic [7:0] rise;
    logic [7:0] fall;
  } data_pair_s;
  typedef struct packed {
    logic rise;
    logic fall;
  } mask_pair_s;
  typedef struct packed {
    logic active;
    logic write;
    logic auto_close;
    logic [2:0] bank;
    logic [2:0] start;
    logic [1:0] pair;
    logic [2:0] left;
  } burst_s;
endpackage

// ==== ddr3_command_pin_interface.sv ====
`timescale 1ns/10ps
`include "ddr3_pin_defines.svh"
module ddr3_command_pin_interface (
  // System side
  input wire logic clk,
  input wire logic srst,
  // Link clock, reset and clock gate
  input wire logic ck_clk,
  input wire logic reset_n,
  input wire logic cke,
  // Command and address pins
  input wire ddr3_pin_pkg::cmd_s cmd_pins,
  input wire logic die_termination_ctl,
  // Write data, mask and strobe inputs
  input wire ddr3_pin_pkg::data_pair_s dq_i,
  input wire ddr3_pin_pkg::mask_pair_s write_byte_mask,
  input wire logic dqs_t_i,
  input wire logic dqs_c_i,
  // Read data and strobe drivers
  output ddr3_pin_pkg::data_pair_s dq_o,
  output logic dq_oe,
  output logic dqs_t_o,
  output logic dqs_c_o,
  output logic dqs_oe,
  // Termination and input buffer controls
  output logic term_dq_en,
  output logic term_strobe_en,
  output logic cmd_buf_en,
  output logic ctl_buf_en,
  output logic sref_wake,
  // Status in the system domain
  output logic [7:0] open_banks_sys,
  output logic pdn_sys,
  output logic sref_sys,
  output logic access_pulse
);
  import ddr3_pin_pkg::*;

  // Link domain state
  cmd_s cmd_q;
  logic cke_q;
  logic term_pin_q;
  logic term_armed;
  power_e power;
  logic [7:0] open_banks;
  logic [15:0] rows [8];
  logic [15:0] mr [4];
  burst_s burst;
  logic acc_tog;
  logic [7:0] mem [64];

  // Next values and decode
  power_e next_power;
  logic [7:0] next_open;
  logic [15:0] next_rows [8];
  logic [15:0] next_mr [4];
  burst_s next_burst;
  logic next_armed;
  logic next_tog;
  data_pair_s next_dq;
  logic [3:0] code;
  logic live;
  logic cmd_ok;
  logic [1:0] bl;
  logic chop;
  logic acc;
  logic rd_go;
  logic wr_go;
  logic mask_on;
  logic we_r;
  logic we_f;
  logic [5:0] a_rise;
  logic [5:0] a_fall;
  logic rtt_en;
  logic strobe_term_mode;

  // Array slot of one beat; sequential order wrapping in eight
  function automatic logic [5:0] beat_addr(input logic [2:0] bank,
                                           input logic [2:0] start,
                                           input logic [1:0] pair,
                                           input logic hi);
    logic [2:0] off;
    off = 3'(start + {pair, hi});
    return {bank, off};
  endfunction

  // Command decode, bank tracking, power state and burst sequencing
  always_comb begin
    next_power = power;
    next_open = open_banks;
    next_rows = rows;
    next_mr = mr;
    next_burst = burst;
    next_armed = term_armed | cke_q;
    next_tog = acc_tog;
    code = {cmd_q.cs_n, cmd_q.ras_n, cmd_q.cas_n, cmd_q.we_n};
    live = (power == PW_RUN) && cke_q;
    cmd_ok = live && !cmd_q.cs_n;
    bl = mr[`MR0_IDX][`BL_MSB:`BL_LSB];
    chop = (bl == `BL_FIX4) ||
           ((bl == `BL_OTF) && !cmd_q.addr[`BC_BIT]);
    // Only idle engine takes an access; open row expected
    acc = cmd_ok && ((code == `CMD_RD) || (code == `CMD_WR)) &&
          open_banks[cmd_q.bank_pick] && !burst.active;
    case (power)
      PW_RUN: begin
        if (!cke_q) begin
          if ((code == `CMD_REF) && (open_banks == `BANK_NONE)) begin
            next_power = PW_SREF;
          end else begin
            next_power = PW_PDN;
          end
        end
      end
      PW_PDN: begin
        if (cke_q) begin
          next_power = PW_RUN;
        end
      end
      PW_SREF: begin
        if (cke_q) begin
          next_power = PW_RUN;
        end
      end
      default: next_power = PW_RUN;
    endcase
    // Burst steps only while clocks run, so a stall freezes it
    if (burst.active && live) begin
      next_burst.pair = burst.pair + 2'h1;
      next_burst.left = burst.left - 3'h1;
      if (burst.left == 3'h1) begin
        next_burst.active = 1'b0;
        if (burst.auto_close) begin
          next_open[burst.bank] = 1'b0;
        end
      end
    end
    if (cmd_ok) begin
      case (code)
        `CMD_MODE_LOAD: next_mr[cmd_q.bank_pick[1:0]] = cmd_q.addr;
        `CMD_ACT: begin
          next_open[cmd_q.bank_pick] = 1'b1;
          next_rows[cmd_q.bank_pick] = cmd_q.addr;
        end
        `CMD_PRE: begin
          if (cmd_q.addr[`AP_BIT]) begin
            next_open = `BANK_NONE;
          end else begin
            next_open[cmd_q.bank_pick] = 1'b0;
          end
        end
        default: ;
      endcase
    end
    if (acc) begin
      next_burst.active = 1'b1;
      next_burst.write = (code == `CMD_WR);
      next_burst.auto_close = cmd_q.addr[`AP_BIT];
      next_burst.bank = cmd_q.bank_pick;
      next_burst.start = cmd_q.addr[2:0];
      next_burst.pair = 2'h0;
      next_burst.left = chop ? `PAIRS_CHOP : `PAIRS_FULL;
      next_tog = ~acc_tog;
    end
  end

  // Data path: one rise and one fall beat per link clock
  always_comb begin
    a_rise = beat_addr(burst.bank, burst.start, burst.pair, 1'b0);
    a_fall = beat_addr(burst.bank, burst.start, burst.pair, 1'b1);
    strobe_term_mode = mr[`MODE_ONE_IDX][`TSTROBE_BIT];
    mask_on = !strobe_term_mode;
    // A single-ended strobe never qualifies a beat
    wr_go = burst.active && burst.write && live &&
            (dqs_t_i != dqs_c_i);
    we_r = wr_go && !(mask_on && write_byte_mask.rise);
    we_f = wr_go && !(mask_on && write_byte_mask.fall);
    rd_go = burst.active && !burst.write && live;
    next_dq = '0;
    if (rd_go) begin
      next_dq.rise = mem[a_rise];
      next_dq.fall = mem[a_fall];
    end
  end

  // Link registers; the reset pin acts without the clock
  always_ff @(posedge ck_clk or negedge reset_n) begin
    if (!reset_n) begin
      cmd_q <= '1;
      cke_q <= 1'b0;
      term_pin_q <= 1'b0;
      term_armed <= 1'b0;
      power <= PW_RUN;
      open_banks <= `BANK_NONE;
      rows <= '{default: `ROW_RST};
      mr <= '{default: `MR_RST};
      burst <= '0;
      acc_tog <= 1'b0;
      dq_o <= '0;
      dq_oe <= 1'b0;
      dqs_t_o <= 1'b0;
      dqs_c_o <= 1'b1;
      dqs_oe <= 1'b0;
    end else begin
      cmd_q <= cmd_pins;
      cke_q <= cke;
      term_pin_q <= die_termination_ctl;
      term_armed <= next_armed;
      power <= next_power;
      open_banks <= next_open;
      rows <= next_rows;
      mr <= next_mr;
      burst <= next_burst;
      acc_tog <= next_tog;
      dq_o <= next_dq;
      dq_oe <= rd_go;
      // Strobe held high through both beats of each pair, registered with data
      dqs_t_o <= rd_go;
      dqs_c_o <= !rd_go;
      dqs_oe <= rd_go;
    end
  end

  // Storage array; contents are not reset, like real cells
  always_ff @(posedge ck_clk) begin
    if (we_r) begin
      mem[a_rise] <= dq_i.rise;
    end
    if (we_f) begin
      mem[a_fall] <= dq_i.fall;
    end
  end

  // Termination and buffer gating
  assign rtt_en = |(mr[`MODE_ONE_IDX] & `RTT_MASK);
  assign term_dq_en = term_armed && term_pin_q && rtt_en &&
                      (power != PW_SREF);
  assign term_strobe_en = term_dq_en && strobe_term_mode;
  assign cmd_buf_en = (power == PW_RUN);
  assign ctl_buf_en = (power != PW_SREF);
  // Raw pin on purpose: self-refresh exit needs no clock edge
  assign sref_wake = (power == PW_SREF) && cke;

  // Crossing into the system clock: bits as levels, access as toggle
  logic [10:0] sync1;
  logic [10:0] sync2;
  logic tog3;
  always_ff @(posedge clk) begin
    if (srst) begin
      sync1 <= '0;
      sync2 <= '0;
      tog3 <= 1'b0;
    end else begin
      sync1 <= {acc_tog, power == PW_SREF, power == PW_PDN, open_banks};
      sync2 <= sync1;
      tog3 <= sync2[10];
    end
  end
  assign open_banks_sys = sync2[7:0];
  assign pdn_sys = sync2[8];
  assign sref_sys = sync2[9];
  assign access_pulse = sync2[10] ^ tog3;

  // Checks on the link domain
  default clocking cb @(posedge ck_clk);
  endclocking
  default disable iff (!reset_n);

  a_deselect_ignored: assert property (
    (cmd_q.cs_n && !burst.active) |=> (open_banks == $past(open_banks)))
    else $error("bank state moved on a deselected cycle");
  a_activate_opens: assert property (
    (cmd_ok && code == `CMD_ACT) |=>
      open_banks[$past(cmd_q.bank_pick)] &&
      (rows[$past(cmd_q.bank_pick)] == $past(cmd_q.addr)))
    else $error("activate did not open bank with its row");
  a_precharge_all: assert property (
    (cmd_ok && code == `CMD_PRE && cmd_q.addr[`AP_BIT]) |=>
      (open_banks == `BANK_NONE))
    else $error("precharge all left a bank open");
  a_stopped_frozen: assert property (
    (power != PW_RUN && !burst.active) |=>
      $stable(open_banks) && $stable(burst))
    else $error("state changed while clocks were stopped");
  a_chop_four: assert property (
    (acc && code == `CMD_RD && chop) ##1 live[*2] |->
      dq_oe ##1 dq_oe ##1 !dq_oe)
    else $error("chopped read did not drive two beat pairs");
  a_full_eight: assert property (
    (acc && code == `CMD_RD && !chop) ##1 live[*4] |->
      dq_oe && $past(dq_oe) && $past(dq_oe, 2) ##1 dq_oe ##1 !dq_oe)
    else $error("full read did not drive four beat pairs");
  a_auto_close: assert property (
    (burst.active && live && burst.left == 3'h1 && burst.auto_close) |=>
      !open_banks[$past(burst.bank)])
    else $error("auto-close burst left its bank open");
  a_sref_entry: assert property (
    (power == PW_RUN && !cke_q && code == `CMD_REF &&
     open_banks == `BANK_NONE) |=> (power == PW_SREF) && !term_dq_en)
    else $error("self refresh not entered or termination left on");
  a_term_armed: assert property (
    $rose(term_dq_en) |-> term_armed && $past(cke_q))
    else $error("termination enabled before clock gate registered");
  a_strobe_term: assert property (
    term_strobe_en |-> term_dq_en && mr[`MODE_ONE_IDX][`TSTROBE_BIT])
    else $error("termination strobe active without its mode bit");
endmodule

// ==== ddr3_ctrl_model.sv ====
`timescale 1ns/10ps
`include "ddr3_pin_defines.svh"
module ddr3_ctrl_model (
  // Link clock from the bench
  input wire logic ck_clk,
  // Pins driven toward the device
  output logic reset_n,
  output logic cke,
  output ddr3_pin_pkg::cmd_s cmd_pins,
  output logic die_termination_ctl,
  output ddr3_pin_pkg::data_pair_s dq_i,
  output ddr3_pin_pkg::mask_pair_s write_byte_mask,
  output logic dqs_t_i,
  output logic dqs_c_i
);
  import ddr3_pin_pkg::*;

  // Reset pin low at power-on, gate low until init releases it
  initial begin
    reset_n = 1'b0;
    cke = 1'b0;
    cmd_pins = '1;
    die_termination_ctl = 1'b0;
    dq_i = '0;
    write_byte_mask = '0;
    dqs_t_i = 1'b0;
    dqs_c_i = 1'b0;
  end

  // Level pins change only at a clock edge; the gate is never
  // touched by the access tasks, so it stays high across bursts
  task automatic set_ctl(input logic rst_v, input logic cke_v,
                         input logic odt_v);
    @(posedge ck_clk);
    reset_n <= rst_v;
    cke <= cke_v;
    die_termination_ctl <= odt_v;
  endtask

  // One command cycle, then deselect with flipped lines so a stale
  // address never passes for a fresh one
  task automatic issue(input logic [3:0] code, input logic [2:0] bank,
                       input logic [15:0] addr);
    @(posedge ck_clk);
    cmd_pins <= {code, bank, addr};
    @(posedge ck_clk);
    cmd_pins <= {4'hF, ~bank, ~addr};
  endtask

  // Write beat pairs with the strobe pair driven apart; afterwards
  // the strobes go equal and the data lines show the inverse
  task automatic write_pairs(input logic [63:0] d, input logic [7:0] m,
                             input int n);
    for (int k = 0; k < n; k++) begin
      @(posedge ck_clk);
      dq_i <= d[16*k +: 16];
      write_byte_mask <= m[2*k +: 2];
      dqs_t_i <= 1'b1;
      dqs_c_i <= 1'b0;
    end
    @(posedge ck_clk);
    dq_i <= ~dq_i;
    write_byte_mask <= 2'h0;
    dqs_t_i <= 1'b0;
    dqs_c_i <= 1'b0;
  endtask
endmodule

// ==== ddr3_command_pin_interface_tb.sv ====
`timescale 1ns/10ps
`include "ddr3_pin_defines.svh"
module ddr3_command_pin_interface_tb;
  import ddr3_pin_pkg::*;
  logic clk = 1'b0;
  logic ck_clk = 1'b0;
  logic srst = 1'b1;
  logic reset_n, cke, die_termination_ctl, dqs_t_i, dqs_c_i;
  cmd_s cmd_pins;
  data_pair_s dq_i, dq_o;
  mask_pair_s write_byte_mask;
  logic dq_oe, dqs_t_o, dqs_c_o, dqs_oe, term_dq_en, term_strobe_en;
  logic cmd_buf_en, ctl_buf_en, sref_wake, pdn_sys, sref_sys, access_pulse;
  logic [7:0] open_banks_sys;
  logic [7:0] mem [8];
  logic [15:0] mode_one_vals [3] = '{16'h0804, 16'h0004, 16'h0000};
  logic [1:0] term_exp [3] = '{2'h3, 2'h2, 2'h0};
  int errors = 0;
  int checks = 0;
  int pulses = 0;

  // System clock, and a link clock offset so edges never line up
  always #5 clk = ~clk;
  initial begin
    #2.7;
    forever #15 ck_clk = ~ck_clk;
  end

  // Count accepted accesses as seen in the system domain
  always @(posedge clk) begin
    if (access_pulse === 1'b1) pulses++;
  end

  ddr3_command_pin_interface uut (
    .clk(clk), .srst(srst), .ck_clk(ck_clk), .reset_n(reset_n),
    .cke(cke), .cmd_pins(cmd_pins),
    .die_termination_ctl(die_termination_ctl), .dq_i(dq_i),
    .write_byte_mask(write_byte_mask), .dqs_t_i(dqs_t_i),
    .dqs_c_i(dqs_c_i), .dq_o(dq_o), .dq_oe(dq_oe), .dqs_t_o(dqs_t_o),
    .dqs_c_o(dqs_c_o), .dqs_oe(dqs_oe), .term_dq_en(term_dq_en),
    .term_strobe_en(term_strobe_en), .cmd_buf_en(cmd_buf_en),
    .ctl_buf_en(ctl_buf_en), .sref_wake(sref_wake),
    .open_banks_sys(open_banks_sys), .pdn_sys(pdn_sys),
    .sref_sys(sref_sys), .access_pulse(access_pulse)
  );

  ddr3_ctrl_model ctl (
    .ck_clk(ck_clk), .reset_n(reset_n), .cke(cke), .cmd_pins(cmd_pins),
    .die_termination_ctl(die_termination_ctl), .dq_i(dq_i),
    .write_byte_mask(write_byte_mask), .dqs_t_i(dqs_t_i),
    .dqs_c_i(dqs_c_i)
  );

  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Beat i of a burst carries b+i; beat 2k rides the rise half
  function automatic logic [63:0] pack(input logic [7:0] b);
    logic [63:0] d;
    for (int i = 0; i < 8; i++) d[8*(i^1) +: 8] = b + 8'(i);
    return d;
  endfunction

  // Let the link settle, then let the status flops catch up
  task automatic settle;
    repeat (3) @(posedge ck_clk);
    #1;
  endtask

  // Read from bank three and compare each beat pair as it stands
  task automatic read_check(input logic [15:0] addr, input int n);
    logic [2:0] s;
    int w;
    w = 0;
    ctl.issue(`CMD_RD, 3'h3, addr);
    while (dq_oe !== 1'b1 && w < 8) begin
      @(posedge ck_clk);
      #1;
      w++;
    end
    for (int k = 0; k < n; k++) begin
      s = addr[2:0] + 3'(2 * k);
      chk("dq_o", {mem[s], mem[s + 3'h1]}, dq_o);
      chk("dqs", 16'h0002, 16'({dqs_t_o, dqs_c_o}));
      @(posedge ck_clk);
      #1;
    end
    chk("dq_oe end", 16'h0000, 16'(dq_oe));
  endtask

  task automatic print_verdict;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Hang guard, well beyond the hundred or so link cycles the tests need
  initial begin
    #100000;
    errors++;
    print_verdict;
  end

  initial begin
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    chk("term in reset", 16'h0000, 16'(term_dq_en));
    chk("dqs idle", 16'h0001, 16'({dqs_oe, dqs_t_o, dqs_c_o}));
    ctl.set_ctl(1'b1, 1'b0, 1'b0);
    ctl.set_ctl(1'b1, 1'b1, 1'b0);
    settle;
    $display("test reset done");
    foreach (mode_one_vals[i]) begin
      ctl.issue(`CMD_MODE_LOAD, 3'h1, mode_one_vals[i]);
      ctl.set_ctl(1'b1, 1'b1, 1'b1);
      settle;
      chk("term", 16'(term_exp[i]),
          16'({term_dq_en, term_strobe_en}));
    end
    $display("test termination done");
    ctl.issue(`CMD_MODE_LOAD, 3'h0, 16'h0001);
    ctl.issue(`CMD_ACT, 3'h3, 16'h1234);
    settle;
    chk("open", 16'h0008, 16'(open_banks_sys));
    for (int i = 0; i < 8; i++) mem[i] = 8'h10 + 8'(i);
    ctl.issue(`CMD_WR, 3'h3, 16'h1000);
    ctl.write_pairs(pack(8'h10), 8'h00, 4);
    for (int i = 0; i < 4; i++) if (i != 1) mem[i] = 8'hA0 + 8'(i);
    ctl.issue(`CMD_WR, 3'h3, 16'h0000);
    ctl.write_pairs(pack(8'hA0), 8'h01, 2);
    read_check(16'h1004, 4);
    ctl.issue(4'hD, 3'h3, 16'h1000);
    repeat (2) @(posedge ck_clk);
    #1;
    chk("masked read", 16'h0000, 16'(dq_oe));
    $display("test data done");
    ctl.set_ctl(1'b1, 1'b0, 1'b0);
    settle;
    chk("pdn", 16'h0005, 16'({pdn_sys, cmd_buf_en, ctl_buf_en}));
    ctl.issue(`CMD_PRE, 3'h0, 16'h0400);
    ctl.set_ctl(1'b1, 1'b1, 1'b0);
    settle;
    chk("pdn exit", 16'h0008, 16'({pdn_sys, open_banks_sys}));
    $display("test power-down done");
    read_check(16'h0400, 2);
    settle;
    chk("auto close", 16'h0000, 16'(open_banks_sys));
    ctl.issue(`CMD_ACT, 3'h1, 16'h0001);
    ctl.issue(`CMD_ACT, 3'h2, 16'h0002);
    ctl.issue(`CMD_PRE, 3'h1, 16'h0000);
    settle;
    chk("pre one", 16'h0004, 16'(open_banks_sys));
    ctl.issue(`CMD_PRE, 3'h0, 16'h0400);
    settle;
    chk("pre all", 16'h0000, 16'(open_banks_sys));
    $display("test precharge done");
    fork
      ctl.set_ctl(1'b1, 1'b0, 1'b0);
      ctl.issue(`CMD_REF, 3'h0, 16'h0000);
    join
    settle;
    chk("sref", 16'h0002, 16'({sref_sys, ctl_buf_en}));
    ctl.set_ctl(1'b1, 1'b1, 1'b0);
    #1;
    chk("sref wake", 16'h0001, 16'(sref_wake));
    settle;
    chk("sref exit", 16'h0000, 16'(sref_sys));
    $display("test self refresh done");
    ctl.issue(`CMD_ACT, 3'h5, 16'h0005);
    ctl.set_ctl(1'b0, 1'b1, 1'b0);
    settle;
    chk("reset banks", 16'h0000, 16'(open_banks_sys));
    chk("accesses", 16'h0004, 16'(pulses));
    $display("test async reset done");
    print_verdict;
  end
endmodule
